// *** dv/swc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module swc_checker #(
	parameter int IRQ_N = 3
) (
	// Inputs of the block
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_sleep_exec,
	input wire logic [IRQ_N-1:0] i_irq_flag,
	input wire logic [IRQ_N-1:0] i_irq_enable,
	input wire logic i_watchdog_enable,
	input wire logic i_watchdog_expired,
	input wire logic i_master_clear_pin_n,
	// Outputs of the block
	input wire logic o_core_halt,
	input wire logic o_fetch_valid,
	input wire logic [12:0] o_fetch_addr,
	input wire logic o_vector_jump,
	input wire logic o_watchdog_clear,
	input wire logic o_osc_driver_on,
	input wire logic o_device_reset,
	input wire logic o_timeout_flag,
	input wire logic o_powerdown_flag,
	input wire logic o_asleep
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	AST_ENTRY:
		assert property (i_sleep_exec && !o_core_halt && i_master_clear_pin_n && !i_watchdog_expired
			|=> o_asleep && !o_powerdown_flag && o_timeout_flag) else $error("sleep entry wrong");
	AST_WAKE:
		assert property (o_asleep && |(i_irq_flag & i_irq_enable) && i_master_clear_pin_n
			|=> !o_asleep && !o_device_reset) else $error("irq wake wrong");
	AST_HOLD:
		assert property (o_asleep && !(|(i_irq_flag & i_irq_enable)) && !i_watchdog_expired && i_master_clear_pin_n
			|=> o_asleep && o_core_halt) else $error("sleep not held");
	AST_WDT_WAKE:
		assert property (o_asleep && i_watchdog_enable && i_watchdog_expired && i_master_clear_pin_n
			|=> !o_timeout_flag && !o_device_reset) else $error("watchdog wake wrong");
	AST_CLR:
		assert property ($fell(o_asleep) && !o_device_reset |-> o_watchdog_clear) else $error("no watchdog clear");
	AST_MASTER_CLEAR_PIN:
		assert property (!i_master_clear_pin_n |=> o_device_reset) else $error("no master clear reset");
	AST_OSC:
		assert property (o_asleep |-> !o_osc_driver_on) else $error("driver on in sleep");
	AST_VEC:
		assert property (o_vector_jump |-> o_fetch_valid && o_fetch_addr == swc_pkg::SWC_IRQ_VECTOR)
			else $error("bad vector");
	COV_WAKE: cover property ($fell(o_asleep));
	COV_VEC: cover property (o_vector_jump);
	COV_WDT: cover property (o_asleep ##1 !o_timeout_flag);
endmodule
bind swc_sleep_wakeup_control swc_checker #(.IRQ_N(IRQ_N)) chk (.i_clk, .i_resetn, .i_sleep_exec,
	.i_irq_flag, .i_irq_enable, .i_watchdog_enable, .i_watchdog_expired, .i_master_clear_pin_n,
	.o_core_halt, .o_fetch_valid, .o_fetch_addr, .o_vector_jump, .o_watchdog_clear, .o_osc_driver_on,
	.o_device_reset, .o_timeout_flag, .o_powerdown_flag, .o_asleep);
`default_nettype wire

// *** dv/swc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module swc_core_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Core handshake
	input wire logic i_core_halt,
	output logic o_instr_done
);
	logic halt_reg;
	// The word after sleep is a no-operation that retires one cycle after release.
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			halt_reg <= 1'b0;
			o_instr_done <= 1'b0;
		end
		else
		begin
			halt_reg <= i_core_halt;
			o_instr_done <= halt_reg && !i_core_halt;
		end
	end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic slp = 1'b0;
	logic global_irq_enable = 1'b0;
	logic wen = 1'b1;
	logic wexp = 1'b0;
	logic master_clear_pin_n = 1'b1;
	logic [1:0] osc = 2'h0;
	logic [12:0] pc = 13'h0000;
	logic [2:0] flag = 3'h0;
	logic [2:0] en = 3'h7;
	logic done, halt, fv, vj, wclr, oscon, drst, to, pd, asleep;
	logic [12:0] fa;
	int bad_count = 0;
	int checks = 0;
	int dly [4] = '{swc_pkg::SWC_XTAL_TOSC / 64, swc_pkg::SWC_RC_CYC, swc_pkg::SWC_INTERNAL_RC_OSCILLATOR_CYC, swc_pkg::SWC_EXT_CYC};
	swc_sleep_wakeup_control #(.IRQ_N(3), .TOSC_PER_CLK(64)) dut (.i_clk(clk), .i_resetn(resetn),
		.i_sleep_exec(slp), .i_instr_done(done), .i_program_counter(pc), .i_global_irq_enable(global_irq_enable),
		.i_irq_flag(flag), .i_irq_enable(en), .i_watchdog_enable(wen), .i_watchdog_expired(wexp),
		.i_master_clear_pin_n(master_clear_pin_n), .i_osc_mode(osc), .o_core_halt(halt), .o_fetch_valid(fv),
		.o_fetch_addr(fa), .o_vector_jump(vj), .o_watchdog_clear(wclr), .o_osc_driver_on(oscon),
		.o_device_reset(drst), .o_timeout_flag(to), .o_powerdown_flag(pd), .o_asleep(asleep));
	swc_core_model core (.i_clk(clk), .i_resetn(resetn), .i_core_halt(halt), .o_instr_done(done));
	always #5 clk = ~clk;
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d bad %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic sleep_at(input logic [12:0] a);
		@(posedge clk);
		slp <= 1'b1;
		pc <= a;
		@(posedge clk);
		slp <= 1'b0;
		#1;
		chk(fv, 1'b1);
		chk(fa, a + 13'h0001);
		chk(pd, 1'b0);
		chk({asleep, to, oscon, wclr}, 4'hD);
	endtask
	task automatic resume(input logic g);
		int n;
		logic seen;
		chk({asleep, wclr, oscon}, 3'h3);
		n = 0;
		while (halt === 1'b1 && n < 300)
		begin
			tick;
			n++;
		end
		// Halt is released one edge after the start-up count has run out.
		chk(13'(n), 13'(dly[osc] + 1));
		if (n >= 300)
			complete_run;
		seen = 1'b0;
		for (int k = 0; k < 6; k++)
		begin
			tick;
			if (vj === 1'b1)
			begin
				seen = 1'b1;
				chk(fa, swc_pkg::SWC_IRQ_VECTOR);
				chk(fv, 1'b1);
			end
		end
		chk(seen, g);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) tick;
		chk({pd, to}, 2'h3);
		for (int m = 0; m < 4; m++)
		begin
			osc <= 2'(m);
			global_irq_enable <= m[0];
			flag[m % 3] <= 1'b1;
			sleep_at(13'h0100 + 13'(m));
			tick;
			flag <= 3'h0;
			resume(m[0]);
			$display("mode %0d done", m);
		end
		global_irq_enable <= 1'b0;
		en <= 3'h5;
		flag <= 3'h2;
		sleep_at(13'h0FFF);
		repeat (4) tick;
		chk(asleep, 1'b1);
		wexp <= 1'b1;
		tick;
		wexp <= 1'b0;
		flag <= 3'h0;
		chk({to, drst}, 2'h0);
		resume(1'b0);
		$display("watchdog wake done");
		wexp <= 1'b1;
		tick;
		wexp <= 1'b0;
		chk(drst, 1'b1);
		repeat (3) tick;
		sleep_at(13'h0020);
		master_clear_pin_n <= 1'b0;
		tick;
		chk(drst, 1'b1);
		master_clear_pin_n <= 1'b1;
		repeat (3) tick;
		$display("reset tests done");
		complete_run;
	end
endmodule
`default_nettype wire

// *** hdl/swc_delay.sv ***
`timescale 1ns/1ps
`default_nettype none

// Down counter that pulses once its loaded count has elapsed.
module swc_delay #(
	parameter int CNT_W = 12
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Control
	input wire logic i_load,
	input wire logic [CNT_W-1:0] i_count,
	output logic o_done
);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic busy_reg;
	logic busy_next;
	logic done_reg;
	logic done_next;

	initial
	begin
		if (CNT_W < 2)
			$error("Counter width too small.");
	end

	always_comb
	begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (i_load)
		begin
			cnt_next = i_count;
			busy_next = 1'b1;
		end
		else if (busy_reg)
		begin
			if (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1})
			begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
			else
				cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign o_done = done_reg;

endmodule

`default_nettype wire

// *** hdl/swc_pkg.sv ***
package swc_pkg;

	// Interrupt vector taken after wake when global enable is set.
	localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;
	localparam int SWC_PC_W = 13;
	// Program counter step to the prefetched instruction.
	localparam logic [12:0] SWC_PC_STEP = 13'h0001;

	// Oscillator start-up delays.
	localparam int SWC_XTAL_TOSC = 1024;
	localparam int SWC_RC_NS = 1000;
	localparam int SWC_INTERNAL_RC_OSCILLATOR_NS = 2000;
	localparam int SWC_CLK_NS = 10;
	localparam int SWC_RC_CYC = (SWC_RC_NS / SWC_CLK_NS < 1) ? 1 : SWC_RC_NS / SWC_CLK_NS;
	localparam int SWC_INTERNAL_RC_OSCILLATOR_CYC = (SWC_INTERNAL_RC_OSCILLATOR_NS / SWC_CLK_NS < 1) ? 1 : SWC_INTERNAL_RC_OSCILLATOR_NS / SWC_CLK_NS;
	// An external clock needs no start-up wait beyond one cycle.
	localparam int SWC_EXT_CYC = 1;
	localparam int SWC_CNT_W = 12;

	// Oscillator mode codes on i_osc_mode.
	localparam logic [1:0] SWC_OSC_XTAL = 2'h0;
	localparam logic [1:0] SWC_OSC_RC = 2'h1;
	localparam logic [1:0] SWC_OSC_INTRC = 2'h2;
	localparam logic [1:0] SWC_OSC_EXT = 2'h3;

	typedef enum logic [2:0] {
		SWC_RUN,
		SWC_SLEEP,
		SWC_START,
		SWC_EXEC_NEXT,
		SWC_VECTOR
	} swc_state_type;

endpackage

// *** hdl/swc_sleep_wakeup_control.sv ***
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: Sleep ends on a master-clear reset, a watchdog wake with the watchdog enabled, or an enabled interrupt.
// R2: Master clear in sleep resets the device while watchdog and interrupt wakes resume execution.
// R3: The power-down flag is set at power-up and cleared by every sleep instruction.
// R4: The timeout flag is cleared when a watchdog expiry woke the device.
// R5: The instruction at program counter plus one is prefetched while sleep executes.
// R6: An interrupt wakes the device only if its own enable is set, whatever the global enable.
// R7: With the global enable clear, execution continues after the sleep instruction.
// R8: With the global enable set, the next instruction runs and then the core branches to vector 0004h.
// R9: Software should place a no-operation instruction after sleep when running it on wake is unwanted.
// R10: The watchdog is cleared on every wake from sleep.
// R11: A pending enabled interrupt with the global enable clear lets sleep complete and wakes at once.
// R12: Execution resumes after 1024 oscillator periods in crystal modes, about 1 us in RC and 2 us internal.
// R13: Entering sleep with the watchdog enabled clears it, clears power-down, sets timeout and stops the driver.
// R14: A watchdog expiry resets the device when running and wakes it when asleep.
// R15: During sleep the program counter is held and execution is suspended.
module swc_sleep_wakeup_control #(
	parameter int IRQ_N = 3,
	parameter int TOSC_PER_CLK = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Core
	input wire logic i_sleep_exec,
	input wire logic i_instr_done,
	input wire logic [swc_pkg::SWC_PC_W-1:0] i_program_counter,
	input wire logic i_global_irq_enable,
	// Interrupt sources
	input wire logic [IRQ_N-1:0] i_irq_flag,
	input wire logic [IRQ_N-1:0] i_irq_enable,
	// Watchdog, master clear, configuration
	input wire logic i_watchdog_enable,
	input wire logic i_watchdog_expired,
	input wire logic i_master_clear_pin_n,
	input wire logic [1:0] i_osc_mode,
	// Core control
	output logic o_core_halt,
	output logic o_fetch_valid,
	output logic [swc_pkg::SWC_PC_W-1:0] o_fetch_addr,
	output logic o_vector_jump,
	// Watchdog, oscillator and reset control
	output logic o_watchdog_clear,
	output logic o_osc_driver_on,
	output logic o_device_reset,
	// Status
	output logic o_timeout_flag,
	output logic o_powerdown_flag,
	output logic o_asleep
);

	localparam int XTAL_CYC = (swc_pkg::SWC_XTAL_TOSC / TOSC_PER_CLK < 1) ? 1
		: swc_pkg::SWC_XTAL_TOSC / TOSC_PER_CLK;

	initial
	begin
		if (IRQ_N < 1 || TOSC_PER_CLK < 1 || XTAL_CYC >= (1 << swc_pkg::SWC_CNT_W))
			$error("Unsupported parameter values.");
	end

	swc_pkg::swc_state_type state_reg, state_next;
	logic halt_reg, halt_next;
	logic fetch_valid_reg, fetch_valid_next;
	logic [swc_pkg::SWC_PC_W-1:0] fetch_addr_reg, fetch_addr_next;
	logic vector_reg, vector_next;
	logic wdt_clr_reg, wdt_clr_next;
	logic osc_on_reg, osc_on_next;
	logic dev_rst_reg, dev_rst_next;
	logic to_reg, to_next;
	logic pd_reg, pd_next;
	logic gie_reg, gie_next;
	logic asleep_reg, asleep_next;
	logic [swc_pkg::SWC_CNT_W-1:0] delay_count;
	logic delay_load;
	logic delay_done;
	logic irq_wake;

	assign irq_wake = |(i_irq_flag & i_irq_enable); // [R6] [R11]

	always_comb
	begin
		unique case (i_osc_mode)
			swc_pkg::SWC_OSC_XTAL: delay_count = XTAL_CYC[swc_pkg::SWC_CNT_W-1:0]; // [R12]
			swc_pkg::SWC_OSC_RC: delay_count = swc_pkg::SWC_RC_CYC[swc_pkg::SWC_CNT_W-1:0]; // [R12]
			swc_pkg::SWC_OSC_INTRC: delay_count = swc_pkg::SWC_INTERNAL_RC_OSCILLATOR_CYC[swc_pkg::SWC_CNT_W-1:0]; // [R12]
			swc_pkg::SWC_OSC_EXT: delay_count = swc_pkg::SWC_EXT_CYC[swc_pkg::SWC_CNT_W-1:0]; // [R12]
		endcase
	end

	swc_delay #(
		.CNT_W(swc_pkg::SWC_CNT_W)
	) u_start_delay (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_load(delay_load),
		.i_count(delay_count),
		.o_done(delay_done)
	);

	always_comb
	begin
		state_next = state_reg;
		halt_next = halt_reg;
		fetch_valid_next = 1'b0;
		fetch_addr_next = fetch_addr_reg;
		vector_next = 1'b0;
		wdt_clr_next = 1'b0;
		osc_on_next = osc_on_reg;
		dev_rst_next = 1'b0;
		to_next = to_reg;
		pd_next = pd_reg;
		gie_next = gie_reg;
		delay_load = 1'b0;
		if (!i_master_clear_pin_n)
		begin
			// Master clear restarts everything but keeps the status flags for software.
			state_next = swc_pkg::SWC_RUN; // [R1] [R2]
			dev_rst_next = 1'b1; // [R2]
			halt_next = 1'b0;
			osc_on_next = 1'b1;
		end
		else
		begin
			unique case (state_reg)
				swc_pkg::SWC_RUN:
				begin
					if (i_watchdog_enable && i_watchdog_expired)
						dev_rst_next = 1'b1; // [R14]
					else if (i_sleep_exec)
					begin
						fetch_valid_next = 1'b1; // [R5]
						fetch_addr_next = i_program_counter + swc_pkg::SWC_PC_STEP; // [R5]
						pd_next = 1'b0; // [R3] [R13]
						to_next = 1'b1; // [R13]
						wdt_clr_next = 1'b1; // [R13]
						halt_next = 1'b1; // [R15]
						osc_on_next = 1'b0; // [R13]
						state_next = swc_pkg::SWC_SLEEP;
					end
				end
				swc_pkg::SWC_SLEEP:
				begin
					// The sleep instruction completes before any wake is honoured.
					if ((i_watchdog_enable && i_watchdog_expired) || irq_wake) // [R1] [R11] [R14]
					begin
						if (i_watchdog_enable && i_watchdog_expired)
							to_next = 1'b0; // [R4]
						wdt_clr_next = 1'b1; // [R10]
						gie_next = i_global_irq_enable;
						osc_on_next = 1'b1;
						delay_load = 1'b1; // [R12]
						state_next = swc_pkg::SWC_START;
					end
				end
				swc_pkg::SWC_START:
				begin
					if (delay_done)
					begin
						halt_next = 1'b0; // [R2] [R15]
						state_next = swc_pkg::SWC_EXEC_NEXT;
					end
				end
				swc_pkg::SWC_EXEC_NEXT:
				begin
					if (i_instr_done)
					begin
						if (gie_reg)
						begin
							vector_next = 1'b1; // [R8]
							fetch_valid_next = 1'b1; // [R8]
							fetch_addr_next = swc_pkg::SWC_IRQ_VECTOR; // [R8]
						end
						state_next = swc_pkg::SWC_RUN; // [R7]
					end
				end
				swc_pkg::SWC_VECTOR:
					state_next = swc_pkg::SWC_RUN;
				default:
					state_next = swc_pkg::SWC_RUN;
			endcase
		end
		// The sleep status is registered so that the output comes from a flip-flop.
		asleep_next = (state_next == swc_pkg::SWC_SLEEP); // [R15]
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_reg <= swc_pkg::SWC_RUN;
			halt_reg <= 1'b0;
			fetch_valid_reg <= 1'b0;
			fetch_addr_reg <= '0;
			vector_reg <= 1'b0;
			wdt_clr_reg <= 1'b0;
			osc_on_reg <= 1'b1;
			dev_rst_reg <= 1'b1;
			to_reg <= 1'b1;
			pd_reg <= 1'b1; // [R3]
			gie_reg <= 1'b0;
			asleep_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			halt_reg <= halt_next;
			fetch_valid_reg <= fetch_valid_next;
			fetch_addr_reg <= fetch_addr_next;
			vector_reg <= vector_next;
			wdt_clr_reg <= wdt_clr_next;
			osc_on_reg <= osc_on_next;
			dev_rst_reg <= dev_rst_next;
			to_reg <= to_next;
			pd_reg <= pd_next;
			gie_reg <= gie_next;
			asleep_reg <= asleep_next;
		end
	end

	assign o_core_halt = halt_reg;
	assign o_fetch_valid = fetch_valid_reg;
	assign o_fetch_addr = fetch_addr_reg;
	assign o_vector_jump = vector_reg;
	assign o_watchdog_clear = wdt_clr_reg;
	assign o_osc_driver_on = osc_on_reg;
	assign o_device_reset = dev_rst_reg;
	assign o_timeout_flag = to_reg;
	assign o_powerdown_flag = pd_reg;
	assign o_asleep = asleep_reg;

endmodule

`default_nettype wire
